// ### pfs_pkg.sv
// Constants and carrier types for the playfield fine scroll block
package pfs_pkg;

  // ==========================================================
  // Line timing in machine cycles
  localparam logic [6:0] CYC_LAST = 7'h71;
  localparam logic [6:0] CYC_ENTRY = 7'h00;
  localparam logic [6:0] CYC_DLI = 7'h05;
  localparam logic [6:0] CYC_ROW_END = 7'h6c;
  localparam logic [6:0] CYC_LATE = 7'h69;

  // ==========================================================
  // Playfield widths and DMA windows
  localparam logic [1:0] PFW_OFF = 2'h0;
  localparam logic [1:0] PFW_NARROW = 2'h1;
  localparam logic [1:0] PFW_NORMAL = 2'h2;
  localparam logic [1:0] PFW_WIDE = 2'h3;
  localparam logic [6:0] DMA_START_NARROW = 7'h1c;
  localparam logic [6:0] DMA_START_NORMAL = 7'h14;
  localparam logic [6:0] DMA_START_WIDE = 7'h0c;
  localparam logic [6:0] DMA_STOP_NARROW = 7'h5c;
  localparam logic [6:0] DMA_STOP_NORMAL = 7'h64;
  localparam logic [6:0] DMA_STOP_WIDE = 7'h6c;

  // ==========================================================
  // Mode values and mode 8/9 fault thresholds
  localparam logic [3:0] MODE_BLANK = 4'h0;
  localparam logic [3:0] MODE_JUMP = 4'h1;
  localparam logic [3:0] MODE_FIRST_MAP = 4'h8;
  localparam logic [3:0] MODE_MAP_HI = 4'h9;
  localparam logic [3:0] HS_CHAR_BUG = 4'ha;
  localparam logic [3:0] HS_MID_BUG = 4'he;
  localparam logic [2:0] HS_RECOVER_PAIR = 3'h6;
  localparam logic [1:0] REC_THREE = 2'h3;
  localparam logic [1:0] REC_TWO = 2'h2;
  localparam logic [2:0] MASK_CHAR = 3'h1;
  localparam logic [2:0] MASK_MID = 3'h3;
  localparam logic [2:0] MASK_MAP = 3'h7;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [15:0] HSC_IDX = 16'hd404;
  localparam logic [15:0] VSC_IDX = 16'hd405;
  localparam logic [15:0] STAT_IDX = 16'hd406;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic list_line_interrupt;
    logic load_scan_pointer_instruction;
    logic vs;
    logic hs;
    logic [3:0] mode;
  } pfs_instr_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pfs_pix_t;

  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_RUN = 2'b01,
    PF_STUCK = 2'b11
  } pfs_dma_e;

endpackage : pfs_pkg

// ### pfs_top.sv
// Playfield fine scroll control with AXI4-Lite register access
// Overview of operation
// - Scroll bit zero adds one colour clock delay, effective at once
// - Scroll bits one to three move DMA start and stop cycles and decide the mode 8/9 fault
// - Scan counter advance equals fetches made up to the line's DMA end
// - Misaligned stop point after mid-line change keeps DMA running past blank
// - Late blocked fetches still latch bus data and pass it on
// - Instruction bit five enables vertical scroll using the vertical scroll value
// - Entering a scrolled region starts the row counter at the scroll value
// - Leaving a region ends the first clear line when row matches value
// - Scroll value and row counter are four bits and wrap through sixteen
// - Only first and last lines of a region change; modes may mix
// - Blank lines count as unscrolled yet still shorten when ending regions
// - Any mode line may reach sixteen scan lines through scrolling
// - Modes 0 and 1 blank; tall mode 1 refetches list pointer each line
// - Modes 2 and 3 blank rows 8-9 unless code bits 6:5 are both set, and repeat rows 2-7 above
// - Modes 4 and 6 repeat rows 0-7 on rows 8-15
// - Bitmap rows are identical; data fetched on first scan line only
// - Mid-line scroll changes let the row counter cycle past sixteen lines
// - Mode 8/9 after scrolled wide or normal line corrupts at or above thresholds
// - Mode 8/9 corruption persists or recovers by scroll value and mode
// - Narrow playfields never trigger the mode 8/9 corruption
module pfs_top
  import pfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [17:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic instr_load,
  input wire pfs_instr_t instr,
  input wire logic [1:0] pf_width,
  input wire logic [7:0] data_bus,
  input wire logic [7:0] char_code,
  output logic [6:0] line_cycle,
  output logic new_mode_line,
  output logic [3:0] row,
  output logic [3:0] char_row,
  output logic row_blank,
  output logic mode_line_last,
  output logic pf_req,
  output pfs_pix_t pf_pix,
  output logic color_delay,
  output logic ptr_refetch,
  output logic [6:0] scan_advance,
  output logic scan_advance_valid,
  output logic mode89_corrupt
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [6:0] cyc;
    pfs_instr_t ir;
    logic vs;
    logic prev_vs;
    logic first;
    logic [3:0] row;
    logic [3:0] vs_at0;
    logic end_line;
    logic dli_last;
    logic [3:0] hsc;
    logic [3:0] vsc;
    pfs_dma_e dma;
    logic [2:0] phase;
    logic fetch_d;
    logic pf_req;
    pfs_pix_t pix;
    logic [6:0] bytes;
    logic [6:0] adv;
    logic adv_valid;
    logic corrupt;
    logic persist;
    logic [1:0] left;
    logic [3:0] char_row;
    logic row_blank;
    logic refetch;
    logic aw_got;
    logic [15:0] aw_idx;
    logic w_got;
    logic [3:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } pfs_state_t;

  pfs_state_t s;
  pfs_state_t next_s;

  // ==========================================================
  // Helpers
  function automatic logic [3:0] pfs_last_row(input pfs_instr_t ir);
    logic [3:0] r;
    r = 4'h0;
    unique case (ir.mode)
      4'h0: r = {1'b0, ir.load_scan_pointer_instruction, ir.vs, ir.hs};
      4'h2, 4'h4, 4'h6, 4'h8: r = 4'h7;
      4'h3: r = 4'h9;
      4'h5, 4'h7: r = 4'hf;
      4'h9, 4'ha: r = 4'h3;
      4'hb, 4'hd: r = 4'h1;
      4'h1, 4'hc, 4'he, 4'hf: r = 4'h0;
    endcase
    return r;
  endfunction : pfs_last_row

  function automatic logic [2:0] pfs_mask(input logic [3:0] mode);
    logic [2:0] m;
    m = 3'h0;
    unique case (mode)
      4'h2, 4'h3, 4'h4, 4'h5, 4'hd, 4'he, 4'hf: m = MASK_CHAR;
      4'h6, 4'h7, 4'ha, 4'hb, 4'hc: m = MASK_MID;
      4'h8, 4'h9: m = MASK_MAP;
      4'h0, 4'h1: m = 3'h0;
    endcase
    return m;
  endfunction : pfs_mask

  // ==========================================================
  // Combinational next state
  logic [1:0] eff_w;
  logic [6:0] dma_start;
  logic [6:0] dma_stop;
  logic [2:0] mask;
  logic fetch_line;
  logic fetch;
  logic at_stop;
  logic aligned;
  logic exiting;
  logic row_hit;
  logic entering;
  logic prev_char;
  logic prev_mid;
  logic bug;
  logic do_write;

  always_comb begin
    next_s = s;
    mask = pfs_mask(s.ir.mode);
    // Horizontal scroll widens narrow and normal fetch
    eff_w = pf_width;
    if (s.ir.hs && pf_width != PFW_OFF && pf_width != PFW_WIDE) begin
      eff_w = pf_width + 2'h1;
    end
    unique case (eff_w)
      PFW_NARROW: begin
        dma_start = DMA_START_NARROW;
        dma_stop = DMA_STOP_NARROW;
      end
      PFW_NORMAL: begin
        dma_start = DMA_START_NORMAL;
        dma_stop = DMA_STOP_NORMAL;
      end
      PFW_WIDE: begin
        dma_start = DMA_START_WIDE;
        dma_stop = DMA_STOP_WIDE;
      end
      PFW_OFF: begin
        dma_start = CYC_LAST;
        dma_stop = CYC_LAST;
      end
    endcase
    dma_start = dma_start + {4'h0, s.hsc[3:1]};
    dma_stop = dma_stop + {4'h0, s.hsc[3:1]};
    fetch_line = (s.ir.mode > MODE_JUMP) && (s.ir.mode < MODE_FIRST_MAP || s.first);
    at_stop = s.cyc == dma_stop;
    aligned = (dma_stop[2:0] & mask) == s.phase;
    fetch = 1'b0;

    // Line cycle counter
    next_s.cyc = (s.cyc == CYC_LAST) ? CYC_ENTRY : s.cyc + 7'h1;
    if (s.cyc == CYC_ENTRY) begin
      next_s.vs_at0 = s.vsc;
    end

    // Playfield DMA sequencer
    unique case (s.dma)
      PF_IDLE: begin
        if (fetch_line && eff_w != PFW_OFF && s.cyc == dma_start) begin
          next_s.dma = PF_RUN;
          next_s.phase = dma_start[2:0] & mask;
          fetch = 1'b1;
        end
      end
      PF_RUN, PF_STUCK: begin
        fetch = ((s.cyc[2:0] & mask) == s.phase) && !at_stop;
        if (at_stop) begin
          if (aligned && !s.corrupt) begin
            next_s.dma = PF_IDLE;
          end else begin
            next_s.dma = PF_STUCK;
          end
        end
      end
      default: next_s.dma = PF_IDLE;
    endcase
    next_s.fetch_d = fetch;
    next_s.pf_req = fetch && s.cyc <= CYC_LATE;
    next_s.pix.valid = s.fetch_d;
    next_s.pix.data = data_bus;
    next_s.adv_valid = 1'b0;
    if (s.cyc == CYC_LAST) begin
      next_s.bytes = 7'h0;
      next_s.adv = s.bytes + {6'h0, fetch};
      next_s.adv_valid = s.first && s.ir.mode > MODE_JUMP;
    end else begin
      next_s.bytes = s.bytes + {6'h0, fetch};
    end

    // Row counter and mode line end
    exiting = !s.vs && s.prev_vs;
    row_hit = exiting ? (s.row == s.vsc) : (s.row == pfs_last_row(s.ir));
    if (s.cyc == CYC_DLI) begin
      next_s.dli_last = row_hit;
    end
    if (s.cyc == CYC_ROW_END) begin
      next_s.end_line = row_hit;
    end
    if (s.cyc == CYC_LAST) begin
      next_s.row = s.row + 4'h1;
      next_s.first = 1'b0;
      if (s.corrupt && !s.persist) begin
        next_s.left = s.left - 2'h1;
        if (s.left == 2'h1) begin
          next_s.corrupt = 1'b0;
        end
      end
    end

    // New mode line from the display list
    entering = instr.vs && instr.mode != MODE_BLANK && !s.vs;
    prev_char = pfs_mask(s.ir.mode) == MASK_CHAR;
    prev_mid = pfs_mask(s.ir.mode) == MASK_MID;
    bug = s.ir.hs && pf_width >= PFW_NORMAL &&
      ((prev_char && s.hsc >= HS_CHAR_BUG) || (prev_mid && s.hsc >= HS_MID_BUG));
    if (instr_load) begin
      next_s.ir = instr;
      next_s.vs = instr.vs && instr.mode != MODE_BLANK;
      next_s.prev_vs = s.vs;
      next_s.first = 1'b1;
      next_s.end_line = 1'b0;
      next_s.row = entering ? s.vs_at0 : 4'h0;
      if (instr.mode == MODE_FIRST_MAP || instr.mode == MODE_MAP_HI) begin
        if (bug) begin
          next_s.corrupt = 1'b1;
          if (instr.hs) begin
            next_s.persist = 1'b0;
            next_s.left = prev_char ? REC_THREE : REC_TWO;
          end else if (prev_char && s.hsc[3:1] == HS_RECOVER_PAIR) begin
            next_s.persist = 1'b0;
            next_s.left = REC_TWO;
          end else begin
            next_s.persist = 1'b1;
          end
        end
      end else begin
        next_s.corrupt = 1'b0;
      end
    end

    // Row mapping and blanking
    next_s.row_blank = 1'b0;
    next_s.char_row = s.row;
    next_s.refetch = next_s.ir.mode == MODE_JUMP && !next_s.first;
    unique case (s.ir.mode)
      4'h0, 4'h1: next_s.row_blank = 1'b1;
      4'h2, 4'h3: begin
        if (s.row >= 4'ha) begin
          next_s.char_row = s.row - 4'h8;
        end
        if (s.row[3:1] == 3'h4 && char_code[6:5] != 2'h3) begin
          next_s.row_blank = 1'b1;
        end
      end
      4'h4, 4'h6: next_s.char_row = {1'b0, s.row[2:0]};
      4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: next_s.char_row = 4'h0;
      4'h5, 4'h7: next_s.char_row = s.row;
    endcase

    // AXI4-Lite write channel
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_idx = s_axi_awaddr[17:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata[3:0];
      next_s.w_lane0 = s_axi_wstrb[0];
    end
    do_write = s.aw_got && s.w_got && !s.bvalid;
    if (do_write) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.aw_idx == HSC_IDX) begin
        if (s.w_lane0) begin
          next_s.hsc = s.w_data;
        end
      end else if (s.aw_idx == VSC_IDX) begin
        if (s.w_lane0) begin
          next_s.vsc = s.w_data;
        end
      end else if (s.aw_idx != STAT_IDX) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // AXI4-Lite read channel
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      if (s_axi_araddr[17:2] == STAT_IDX) begin
        next_s.rdata = {9'h0, s.adv, 6'h0, s.dma, s.corrupt, s.vs, s.end_line, s.first, s.row};
      end else if (s_axi_araddr[17:2] != HSC_IDX && s_axi_araddr[17:2] != VSC_IDX) begin
        next_s.rresp = RESP_SLVERR;
      end
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign line_cycle = s.cyc;
  assign new_mode_line = s.end_line;
  assign row = s.row;
  assign char_row = s.char_row;
  assign row_blank = s.row_blank;
  assign mode_line_last = s.dli_last;
  assign pf_req = s.pf_req;
  assign pf_pix = s.pix;
  assign color_delay = s.hsc[0];
  assign ptr_refetch = s.refetch;
  assign scan_advance = s.adv;
  assign scan_advance_valid = s.adv_valid;
  assign mode89_corrupt = s.corrupt;

endmodule : pfs_top

// ### pfs_assertions.sv
// Concurrent checks on the fine scroll block ports
module pfs_checker
  import pfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic instr_load,
  input wire pfs_instr_t instr,
  input wire logic [1:0] pf_width,
  input wire logic [7:0] data_bus,
  input wire logic [6:0] line_cycle,
  input wire logic new_mode_line,
  input wire logic [3:0] row,
  input wire logic mode_line_last,
  input wire pfs_pix_t pf_pix,
  input wire logic color_delay,
  input wire logic s_axi_bvalid,
  input wire logic ptr_refetch,
  input wire logic scan_advance_valid,
  input wire logic mode89_corrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic live;
  assign live = aresetn && clk_en;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Line and row sequencing
  sequence line_end;
    live && line_cycle == 7'h71;
  endsequence
  sequence load_seen;
    live && instr_load;
  endsequence
  chk_line_wrap: assert property (line_end |=> line_cycle == 7'h00)
    else $error("line cycle did not wrap");
  chk_line_step: assert property (live && line_cycle != 7'h71 |=> line_cycle == $past(line_cycle) + 7'h01)
    else $error("line cycle did not step");
  chk_row_step: assert property (line_end |=> row == $past(row) + 4'h1)
    else $error("row did not step at line end");
  chk_row_zero: assert property (load_seen ##0 (!instr.vs || instr.mode == MODE_BLANK) |=> row == 4'h0)
    else $error("unscrolled line did not start at row zero");
  chk_new_clear: assert property (load_seen |=> !new_mode_line && !ptr_refetch)
    else $error("load did not open a fresh first scan line");
  chk_last_rise: assert property ($rose(mode_line_last) |-> line_cycle == 7'h06)
    else $error("last line flag rose off cycle six");
  // ==========================================================
  // Data path and scroll effects
  chk_pix_data: assert property (live && pf_pix.valid |-> pf_pix.data == $past(data_bus))
    else $error("pixel data not taken from bus");
  chk_delay_cause: assert property (live && !$stable(color_delay) |-> s_axi_bvalid || $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2))
    else $error("colour delay moved without a write");
  chk_adv_pulse: assert property (live && scan_advance_valid |=> !scan_advance_valid)
    else $error("advance strobe longer than one cycle");
  chk_narrow_clean: assert property ($rose(mode89_corrupt) |-> $past(pf_width) != PFW_NARROW)
    else $error("corruption raised on narrow width");
endmodule : pfs_checker

bind pfs_top pfs_checker i_pfs_checker (.aclk, .aresetn, .clk_en, .instr_load, .instr, .pf_width, .data_bus,
  .line_cycle, .new_mode_line, .row, .mode_line_last, .pf_pix, .color_delay, .s_axi_bvalid, .ptr_refetch,
  .scan_advance_valid, .mode89_corrupt);

// ### pfs_mem_model.sv
// Memory bus and display list source for the fine scroll block
module pfs_mem_model
  import pfs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [6:0] line_cycle,
  input wire logic new_mode_line,
  input wire logic pf_req,
  output logic instr_load,
  output pfs_instr_t instr,
  output logic [7:0] data_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] prog [$];
  logic first;
  logic [7:0] addr;
  // ==========================================================
  // Instruction at cycle 1, data or toggling bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_load <= 1'b0;
      instr <= 8'h00;
      first <= 1'b1;
      addr <= 8'h00;
      data_bus <= 8'h5a;
    end else begin
      instr_load <= line_cycle == 7'h00 && (new_mode_line || first);
      if (line_cycle == 7'h00 && (new_mode_line || first)) begin
        first <= 1'b0;
        instr <= (prog.size() > 0) ? prog.pop_front() : 8'h00;
      end
      addr <= addr + {7'h00, pf_req};
      data_bus <= pf_req ? addr : ~data_bus;
    end
  end
endmodule : pfs_mem_model

// ### testbench.sv
// Self-checking bench for the playfield fine scroll block
module testbench
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, instr_load, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_arready, s_axi_rvalid, new_mode_line, row_blank, mode_line_last, pf_req, color_delay, ptr_refetch;
  logic scan_advance_valid, mode89_corrupt;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, e;
  logic [3:0] s_axi_wstrb = 4'hf, row, char_row;
  logic [1:0] s_axi_bresp, s_axi_rresp, pf_width = PFW_NORMAL;
  logic [7:0] data_bus, char_code = 8'h41;
  logic [6:0] line_cycle, scan_advance;
  pfs_instr_t instr;
  pfs_pix_t pf_pix;
  int fail_count = 0, check_count = 0, cyc = 0, t = 0, n, loads = 0, tl = 0;
  // Step: instr, vscroll, hscroll, height, first row, width, corrupt
  logic [31:0] tab [17] = '{32'h02000808, 32'h22310538, 32'h22300808, 32'h02300408, 32'h2fd004d8,
    32'h0f300408, 32'h30300408, 32'h24000808, 32'h00f01008, 32'h21e003e8, 32'h01100208, 32'h17001004,
    32'h120a0808, 32'h080a0809, 32'h120a0804, 32'h080a0804, 32'h00000104};

  pfs_top i_pfs_top (.aclk, .aresetn, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .instr_load,
    .instr, .pf_width, .data_bus, .char_code, .line_cycle, .new_mode_line, .row, .char_row, .row_blank,
    .mode_line_last, .pf_req, .pf_pix, .color_delay, .ptr_refetch, .scan_advance, .scan_advance_valid,
    .mode89_corrupt);
  pfs_mem_model i_pfs_mem_model (.aclk, .aresetn, .line_cycle, .new_mode_line, .pf_req, .instr_load, .instr,
    .data_bus);

  always #4 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // Load count and load time, so a load during register writes is not missed
  always @(posedge aclk) begin
    if (instr_load === 1'b1) begin
      loads <= loads + 1;
      tl <= cyc;
    end
  end

  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 40);
    if (k >= 40) fail_count++;
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 40);
    if (k >= 40) fail_count++;
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, er);
    if (er == RESP_OKAY) check(s_axi_rdata, ed);
  endtask : rd

  // ==========================================================
  // Main sequence
  initial begin
    for (int k = 0; k < 17; k++) i_pfs_mem_model.prog.push_back(tab[k][31:24]);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 17; k++) begin
      e = tab[k];
      n = 0;
      do begin @(posedge aclk); #1; n++; end while (loads <= k && n < 3000);
      if (n >= 3000) fail_count++;
      if (k > 0) check((tl - t) / 114, tab[k-1][15:8]);
      t = tl;
      if (k == 16) break;
      @(posedge aclk);
      #1;
      check(row, e[7:4]);
      if (k == 11) begin
        do begin @(posedge aclk); #1; end while (line_cycle != 7'h28);
        wr(HSC_IDX, 32'h00000008, RESP_OKAY);
        n = 0;
        do begin @(posedge aclk); #1; n++; end while (scan_advance_valid !== 1'b1 && n < 200);
        check(scan_advance, 7'h15);
        check(color_delay, 1'b0);
      end
      n = 0;
      do begin @(posedge aclk); #1; n++; end while (new_mode_line !== 1'b1 && n < 3000);
      if (n >= 3000) fail_count++;
      check(ptr_refetch, e[27:24] == 4'h1 && e[15:8] > 8'h01);
      check(row_blank, e[27:25] == 3'h0);
      check(mode89_corrupt, e[0]);
      wr(VSC_IDX, {28'h0, tab[k+1][23:20]}, RESP_OKAY);
      wr(HSC_IDX, {28'h0, tab[k+1][19:16]}, RESP_OKAY);
      pf_width <= tab[k+1][3:2];
      repeat (2) @(posedge aclk);
      #1;
      check(color_delay, tab[k+1][16]);
    end
    wr(16'hd408, 32'h00000001, RESP_SLVERR);
    rd(16'hd408, 32'h00000000, RESP_SLVERR);
    rd(HSC_IDX, 32'h00000000, RESP_OKAY);
    rd(VSC_IDX, 32'h00000000, RESP_OKAY);
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    finish_test();
  end
endmodule : testbench
